// file: inc/data_mem_pkg.sv
// Purpose: Shared constants and types for the banked data memory decoder.
// Assumes: Two implemented banks of 128 bytes; core registers mirrored in both.
// Notes:   Peripheral register contents live in the peripheral blocks.
`default_nettype none

package data_mem_pkg;

  localparam int ADDR_W = 9;
  localparam int OFS_W = 7;
  localparam int DATA_W = 8;
  localparam int BANK_BYTES = 128;
  localparam int GPR_PER_BANK = 96;
  localparam int BANKS_IMPL = 2;
  localparam int GPR_DEPTH = GPR_PER_BANK * BANKS_IMPL;
  localparam int GPR_IDX_W = 8;

  // Core register offsets, identical in both banks; then the RAM base and peripheral offsets.
  localparam logic [6:0] OFS_INDIRECT_WINDOW = 7'h00;
  localparam logic [6:0] OFS_PC_LOW = 7'h02;
  localparam logic [6:0] OFS_CORE_FLAGS = 7'h03;
  localparam logic [6:0] OFS_INDIRECT_PTR = 7'h04;
  localparam logic [6:0] OFS_PC_UPPER_LATCH = 7'h0A;
  localparam logic [6:0] OFS_INT_CONTROL = 7'h0B;
  localparam logic [6:0] OFS_GPR_BASE = 7'h20;
  localparam logic [6:0] OFS_PORT_D = 7'h08;
  localparam logic [6:0] OFS_PORT_E = 7'h09;
  localparam logic [6:0] OFS_ADC_RESULT = 7'h1E;
  localparam logic [6:0] OFS_ADC_CONTROL = 7'h1F;

  // Field positions in core_flags_and_bank_select.
  localparam int FLAG_IND_BANK_BIT = 7;
  localparam int FLAG_BANK_HIGH_BIT = 6;
  localparam int FLAG_BANK_LOW_BIT = 5;
  localparam int CORE_FLAG_W = 5;
  localparam int INT_FLAG_W = 3;

  // Reset values.
  localparam logic [7:0] RST_CORE_FLAGS = 8'h18;
  localparam logic [7:0] RST_PC_LOW = 8'h00;
  localparam logic [7:0] RST_INDIRECT_PTR = 8'h00;
  localparam logic [7:0] RST_PC_UPPER_LATCH = 8'h00;
  localparam logic [7:0] RST_INT_CONTROL = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // One bit per special offset 00h-1Fh that a peripheral owns.
  localparam logic [31:0] PERIPH_MAP_BANK0 = 32'hFFFFF3E2;
  localparam logic [31:0] PERIPH_MAP_BANK1 = 32'h831C73E2;

  typedef enum {
    REG_INDIRECT_WINDOW,
    REG_PC_LOW,
    REG_CORE_FLAGS,
    REG_INDIRECT_PTR,
    REG_PC_UPPER_LATCH,
    REG_INT_CONTROL,
    REG_PERIPH,
    REG_GPR,
    REG_NONE
  } region_t;

endpackage : data_mem_pkg

`default_nettype wire

// file: src/gpr_store.sv
// Purpose: Flip-flop storage for the general purpose RAM of banks 0 and 1.
// Assumes: Write addresses are already range checked by the decoder; read addresses are checked here.
// Notes:   Contents are not reset, as static RAM would not be.
`default_nettype none

module gpr_store #(
  parameter int DEPTH = data_mem_pkg::GPR_DEPTH,
  parameter int WIDTH = data_mem_pkg::DATA_W,
  parameter int IDX_W = data_mem_pkg::GPR_IDX_W
) (
  // Clock and enable
  input wire logic clk_sys,
  input wire logic ce,
  // Write side
  input wire logic we,
  input wire logic [IDX_W-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read side
  input wire logic [IDX_W-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_ff @(posedge clk_sys) begin
      if (ce && we && (waddr == IDX_W'(i))) begin
        mem_q[i] <= wdata;
      end
    end
  end

  assign rdata = (raddr < IDX_W'(DEPTH)) ? mem_q[raddr] : '0;

endmodule : gpr_store

`default_nettype wire

// file: src/banked_data_memory_decoder.sv
// Purpose: Decode core data accesses onto core registers, peripherals and RAM.
// Assumes: One access per enabled cycle; peripheral read data valid in the same cycle.
// Notes:   Read data appears one enabled cycle after the request.
`default_nettype none

module banked_data_memory_decoder #(
  parameter bit PORT_DE_PRESENT = 1'b1,
  parameter bit ADC_PRESENT = 1'b1,
  parameter logic [31:0] PERIPH_MAP0 = data_mem_pkg::PERIPH_MAP_BANK0,
  parameter logic [31:0] PERIPH_MAP1 = data_mem_pkg::PERIPH_MAP_BANK1
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // Core access request
  input wire logic acc_valid,
  input wire logic acc_we,
  input wire logic [6:0] acc_offset,
  input wire logic [7:0] acc_wdata,
  // Core read answer
  output logic rd_valid_q,
  output logic [7:0] rd_data_q,
  // Core hardware updates
  input wire logic pc_low_load,
  input wire logic [7:0] pc_low_value,
  input wire logic core_flags_load,
  input wire logic [4:0] core_flags_value,
  input wire logic [2:0] int_flag_set,
  // Core register contents
  output logic [7:0] pc_low_q,
  output logic [7:0] core_flags_q,
  output logic [7:0] indirect_ptr_q,
  output logic [7:0] pc_upper_latch_q,
  output logic [7:0] int_control_q,
  output logic [1:0] active_bank,
  // Peripheral register port
  output logic periph_sel,
  output logic periph_we,
  output logic [7:0] periph_addr,
  output logic [7:0] periph_wdata,
  input wire logic [7:0] periph_rdata
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Returns the kind of location that a full 9-bit data address names.
  function automatic data_mem_pkg::region_t decode_region(input logic [8:0] a);
    logic [6:0] ofs;
    logic present;
    ofs = a[6:0];
    present = 1'b0;
    if (a[8]) begin
      return data_mem_pkg::REG_NONE;
    end
    if (ofs >= data_mem_pkg::OFS_GPR_BASE) begin
      return data_mem_pkg::REG_GPR;
    end
    case (ofs)
      data_mem_pkg::OFS_INDIRECT_WINDOW: return data_mem_pkg::REG_INDIRECT_WINDOW;
      data_mem_pkg::OFS_PC_LOW: return data_mem_pkg::REG_PC_LOW;
      data_mem_pkg::OFS_CORE_FLAGS: return data_mem_pkg::REG_CORE_FLAGS;
      data_mem_pkg::OFS_INDIRECT_PTR: return data_mem_pkg::REG_INDIRECT_PTR;
      data_mem_pkg::OFS_PC_UPPER_LATCH: return data_mem_pkg::REG_PC_UPPER_LATCH;
      data_mem_pkg::OFS_INT_CONTROL: return data_mem_pkg::REG_INT_CONTROL;
      default: present = a[7] ? PERIPH_MAP1[ofs[4:0]] : PERIPH_MAP0[ofs[4:0]];
    endcase
    if (!PORT_DE_PRESENT && (ofs == data_mem_pkg::OFS_PORT_D ||
                             ofs == data_mem_pkg::OFS_PORT_E)) begin
      present = 1'b0;
    end
    if (!ADC_PRESENT && (ofs == data_mem_pkg::OFS_ADC_RESULT ||
                         ofs == data_mem_pkg::OFS_ADC_CONTROL)) begin
      present = 1'b0;
    end
    return present ? data_mem_pkg::REG_PERIPH : data_mem_pkg::REG_NONE;
  endfunction : decode_region

  logic [8:0] direct_addr;
  logic [8:0] indirect_addr;
  logic [8:0] eff_addr;
  logic use_indirect;
  data_mem_pkg::region_t region;
  logic acc_go;
  logic wr_go;
  logic [7:0] gpr_idx;
  logic [7:0] gpr_rdata;
  logic [6:0] gpr_ofs;

  assign active_bank = {core_flags_q[data_mem_pkg::FLAG_BANK_HIGH_BIT],
                        core_flags_q[data_mem_pkg::FLAG_BANK_LOW_BIT]};
  assign direct_addr = {active_bank, acc_offset};
  // The window offset itself holds no data; it redirects through the pointer.
  assign use_indirect = (acc_offset == data_mem_pkg::OFS_INDIRECT_WINDOW);
  assign indirect_addr = {core_flags_q[data_mem_pkg::FLAG_IND_BANK_BIT], indirect_ptr_q};
  assign eff_addr = use_indirect ? indirect_addr : direct_addr;
  assign region = decode_region(eff_addr);

  assign acc_go = ce && acc_valid;
  assign wr_go = acc_go && acc_we;

  // Banks 0 and 1 stack their 96 RAM bytes into one store.
  assign gpr_ofs = eff_addr[6:0] - data_mem_pkg::OFS_GPR_BASE;
  assign gpr_idx = eff_addr[7] ? 8'(gpr_ofs) + 8'(data_mem_pkg::GPR_PER_BANK)
                               : 8'(gpr_ofs);

  ////////////////////////////////////////////////////////////////////////////////
  // General purpose RAM

  gpr_store #(
    .DEPTH(data_mem_pkg::GPR_DEPTH),
    .WIDTH(data_mem_pkg::DATA_W),
    .IDX_W(data_mem_pkg::GPR_IDX_W)
  ) u_gpr (
    .clk_sys(clk_sys),
    .ce(ce),
    .we(wr_go && (region == data_mem_pkg::REG_GPR)),
    .waddr(gpr_idx),
    .wdata(acc_wdata),
    .raddr(gpr_idx),
    .rdata(gpr_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Peripheral port

  // Strobes are combinational so the peripheral answers within the request cycle.
  assign periph_sel = acc_go && (region == data_mem_pkg::REG_PERIPH);
  assign periph_we = periph_sel && acc_we;
  assign periph_addr = eff_addr[7:0];
  assign periph_wdata = acc_wdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Core registers

  // The core's own flag update lands after the software write, so it wins for bits 4:0; bits 7:5 keep the written value.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      core_flags_q <= data_mem_pkg::RST_CORE_FLAGS;
    end else if (ce) begin
      if (wr_go && region == data_mem_pkg::REG_CORE_FLAGS) begin
        core_flags_q <= acc_wdata;
      end
      if (core_flags_load) begin
        core_flags_q[data_mem_pkg::CORE_FLAG_W-1:0] <= core_flags_value;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pc_low_q <= data_mem_pkg::RST_PC_LOW;
    end else if (ce) begin
      if (pc_low_load) begin
        pc_low_q <= pc_low_value;
      end else if (wr_go && region == data_mem_pkg::REG_PC_LOW) begin
        pc_low_q <= acc_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      indirect_ptr_q <= data_mem_pkg::RST_INDIRECT_PTR;
    end else if (ce && wr_go && region == data_mem_pkg::REG_INDIRECT_PTR) begin
      indirect_ptr_q <= acc_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pc_upper_latch_q <= data_mem_pkg::RST_PC_UPPER_LATCH;
    end else if (ce && wr_go && region == data_mem_pkg::REG_PC_UPPER_LATCH) begin
      pc_upper_latch_q <= acc_wdata;
    end
  end

  // A flag event in the same cycle as a clearing write still sets the flag.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      int_control_q <= data_mem_pkg::RST_INT_CONTROL;
    end else if (ce) begin
      if (wr_go && region == data_mem_pkg::REG_INT_CONTROL) begin
        int_control_q <= acc_wdata | {5'h00, int_flag_set};
      end else begin
        int_control_q <= int_control_q | {5'h00, int_flag_set};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [7:0] rd_mux;

  always_comb begin
    case (region)
      data_mem_pkg::REG_PC_LOW: rd_mux = pc_low_q;
      data_mem_pkg::REG_CORE_FLAGS: rd_mux = core_flags_q;
      data_mem_pkg::REG_INDIRECT_PTR: rd_mux = indirect_ptr_q;
      data_mem_pkg::REG_PC_UPPER_LATCH: rd_mux = pc_upper_latch_q;
      data_mem_pkg::REG_INT_CONTROL: rd_mux = int_control_q;
      data_mem_pkg::REG_PERIPH: rd_mux = periph_rdata;
      data_mem_pkg::REG_GPR: rd_mux = gpr_rdata;
      // Pointer aimed back at the window, absent or unimplemented banks.
      default: rd_mux = data_mem_pkg::READ_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= data_mem_pkg::READ_ZERO;
    end else if (ce) begin
      rd_valid_q <= acc_valid && !acc_we;
      if (acc_valid && !acc_we) begin
        rd_data_q <= rd_mux;
      end
    end
  end

endmodule : banked_data_memory_decoder

`default_nettype wire

// file: verification/banked_data_memory_decoder_monitor.sv
// Purpose: Port level checks for the banked data memory decoder.
// Assumes: ce may drop; checks that follow an access qualify it with ce.
// Notes:   Bound to every instance of the decoder.
`default_nettype none

module banked_data_memory_decoder_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // Core side
  input wire logic acc_valid,
  input wire logic acc_we,
  input wire logic [6:0] acc_offset,
  input wire logic [7:0] acc_wdata,
  input wire logic rd_valid_q,
  input wire logic [7:0] rd_data_q,
  input wire logic [7:0] core_flags_q,
  input wire logic [7:0] indirect_ptr_q,
  input wire logic [1:0] active_bank,
  // Peripheral side
  input wire logic periph_sel,
  input wire logic periph_we,
  input wire logic [7:0] periph_addr,
  input wire logic [7:0] periph_rdata
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  a_read_answer: assert property (ce && acc_valid && !acc_we |=> rd_valid_q)
    else $error("read got no answer");
  a_bank_select: assert property (ce && acc_valid && acc_we && acc_offset == 7'h03 && !active_bank[1]
    |=> active_bank == $past(acc_wdata[6:5]) && core_flags_q[7] == $past(acc_wdata[7]))
    else $error("bank bits not taken from flags write");
  a_upper_banks_dark: assert property (active_bank[1] && acc_offset != 7'h00 |-> !periph_sel)
    else $error("peripheral hit in absent bank");
  a_gpr_not_periph: assert property (acc_valid && acc_offset >= 7'h20 |-> !periph_sel)
    else $error("ram offset hit a peripheral");
  a_periph_strobe: assert property ((periph_we |-> periph_sel) and
    (periph_sel |-> ce && acc_valid && periph_we == acc_we))
    else $error("peripheral write strobe wrong");
  a_periph_addr: assert property (periph_sel && acc_offset != 7'h00
    |-> periph_addr == {active_bank[0], acc_offset})
    else $error("peripheral address wrong");
  a_periph_data: assert property (ce && periph_sel && !acc_we
    |=> rd_data_q == $past(periph_rdata))
    else $error("peripheral read data lost");
  a_ptr_mirror: assert property (ce && acc_valid && acc_we && acc_offset == 7'h04 && !active_bank[1]
    |=> indirect_ptr_q == $past(acc_wdata))
    else $error("pointer write lost");
  c_bank1: cover property (active_bank == 2'h1 && acc_valid);
  c_periph_read: cover property (periph_sel && !acc_we);
  c_indirect: cover property (acc_valid && acc_offset == 7'h00);
endmodule : banked_data_memory_decoder_monitor

bind banked_data_memory_decoder banked_data_memory_decoder_monitor u_mon (.clk_sys, .srst, .ce,
  .acc_valid, .acc_we, .acc_offset, .acc_wdata, .rd_valid_q, .rd_data_q, .core_flags_q,
  .indirect_ptr_q, .active_bank, .periph_sel, .periph_we, .periph_addr, .periph_rdata);

`default_nettype wire

// file: verification/test_banked_data_memory_decoder.sv
// Purpose: Directed bench for the banked data memory decoder.
// Assumes: Small variant, so port D/E and converter offsets are absent.
// Notes:   Inputs change on the falling edge only.
`default_nettype none

module test_banked_data_memory_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic acc_valid = 1'b0;
  logic acc_we = 1'b0;
  logic [6:0] acc_offset = 7'h00;
  logic [7:0] acc_wdata = 8'h00;
  logic pc_low_load = 1'b0;
  logic [7:0] pc_low_value = 8'h00;
  logic core_flags_load = 1'b0;
  logic [4:0] core_flags_value = 5'h00;
  logic [2:0] int_flag_set = 3'h0;
  logic [7:0] periph_rdata = 8'h5A;
  logic rd_valid_q, periph_sel, periph_we, sel_s, we_s;
  logic [7:0] rd_data_q, pc_low_q, core_flags_q, indirect_ptr_q, pc_upper_latch_q;
  logic [7:0] int_control_q, periph_addr, periph_wdata, addr_s, wd_s;
  logic [1:0] active_bank;
  int err_total = 0;
  int cmp_count = 0;

  always #5 clk_sys = ~clk_sys;

  banked_data_memory_decoder #(.PORT_DE_PRESENT(1'b0), .ADC_PRESENT(1'b0)) dut (.clk_sys,
    .srst, .ce, .acc_valid, .acc_we, .acc_offset, .acc_wdata, .rd_valid_q, .rd_data_q,
    .pc_low_load, .pc_low_value, .core_flags_load, .core_flags_value, .int_flag_set,
    .pc_low_q, .core_flags_q, .indirect_ptr_q, .pc_upper_latch_q, .int_control_q,
    .active_bank, .periph_sel, .periph_we, .periph_addr, .periph_wdata, .periph_rdata);
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One access; the select and address are caught once the strobes have settled.
  task automatic acc(input logic we, input logic [6:0] ofs, input logic [7:0] wd);
    @(negedge clk_sys);
    acc_valid = 1'b1;
    acc_we = we;
    acc_offset = ofs;
    acc_wdata = wd;
    #1 sel_s = periph_sel;
    addr_s = periph_addr;
    we_s = periph_we;
    wd_s = periph_wdata;
    @(negedge clk_sys);
    acc_valid = 1'b0;
  endtask : acc

  task automatic rd(input logic [6:0] ofs, input logic [7:0] exp);
    acc(1'b0, ofs, 8'h00);
    chk({7'h00, rd_valid_q}, 8'h01);
    chk(rd_data_q, exp);
  endtask : rd
  ////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    chk(core_flags_q, 8'h18);
    chk({6'h00, active_bank}, 8'h00);
    acc(1'b1, 7'h20, 8'h11);
    acc(1'b1, 7'h7F, 8'h33);
    rd(7'h20, 8'h11);
    chk({7'h00, sel_s}, 8'h00);
    acc(1'b1, 7'h03, 8'h38);
    chk({6'h00, active_bank}, 8'h01);
    acc(1'b1, 7'h0A, 8'h1F);
    chk(pc_upper_latch_q, 8'h1F);
    acc(1'b1, 7'h20, 8'h22);
    acc(1'b1, 7'h7F, 8'h44);
    rd(7'h20, 8'h22);
    acc(1'b1, 7'h04, 8'hA0);
    acc(1'b1, 7'h0F, 8'hFF);
    rd(7'h0F, 8'h00);
    rd(7'h05, 8'h5A);
    chk(addr_s, 8'h85);
    acc(1'b1, 7'h03, 8'h18);
    rd(7'h7F, 8'h33);
    rd(7'h04, 8'hA0);
    rd(7'h0A, 8'h1F);
    rd(7'h00, 8'h22);
    rd(7'h08, 8'h00);
    chk({7'h00, sel_s}, 8'h00);
    rd(7'h1E, 8'h00);
    rd(7'h05, 8'h5A);
    chk({7'h00, sel_s}, 8'h01);
    chk(addr_s, 8'h05);
    acc(1'b1, 7'h06, 8'hC3);
    chk({6'h00, sel_s, we_s}, 8'h03);
    chk(wd_s, 8'hC3);
    // With the enable low a write must leave every register untouched.
    ce = 1'b0;
    acc(1'b1, 7'h0A, 8'h55);
    ce = 1'b1;
    chk(pc_upper_latch_q, 8'h1F);
    acc(1'b1, 7'h04, 8'h03);
    acc(1'b1, 7'h03, 8'h58);
    chk({6'h00, active_bank}, 8'h02);
    acc(1'b1, 7'h20, 8'h77);
    rd(7'h20, 8'h00);
    // The upper bank hides the flags, so the way back is through the pointer.
    acc(1'b1, 7'h00, 8'h18);
    chk({6'h00, active_bank}, 8'h00);
    rd(7'h20, 8'h11);
    @(negedge clk_sys);
    pc_low_load = 1'b1;
    pc_low_value = 8'h3C;
    core_flags_load = 1'b1;
    core_flags_value = 5'h07;
    int_flag_set = 3'h5;
    @(negedge clk_sys);
    pc_low_load = 1'b0;
    core_flags_load = 1'b0;
    int_flag_set = 3'h0;
    chk(pc_low_q, 8'h3C);
    chk(core_flags_q, 8'h07);
    rd(7'h0B, 8'h05);
    print_verdict();
  end

  initial begin
    repeat (2000) @(posedge clk_sys);
    err_total++;
    print_verdict();
  end
endmodule : test_banked_data_memory_decoder

`default_nettype wire
